// [rtl/csv_regs.svh]
`ifndef CSV_REGS_SVH
`define CSV_REGS_SVH

// Object indexes
`define IDX_EXT_SETUP3   16'h3724
`define IDX_STATUS_WORD  16'h6041

// Field positions
`define SW_FOLLOW_BIT    12
`define EXT_TQLIM_BIT    11
`define CW_HALT_BIT      8

// Status bits passed through from the state machine (11, 9..0)
`define SW_PASS_MASK     16'h0bff

// Reset values and ceilings
`define EXT_SETUP3_RST   16'h0000
`define VEL_CEIL         32'h7fffffff
`define SPEED_RST        32'h0000_0000

`endif

// [rtl/csv_pkg.sv]
`default_nettype none

package csv_pkg;
  typedef logic signed [31:0] vel_t;
  typedef logic [15:0]        word_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } run_state_t;
endpackage : csv_pkg

`default_nettype wire

// [rtl/csv_vel_if.sv]
`default_nettype none

interface csv_vel_if;
  import csv_pkg::*;
  logic        cycle;
  vel_t        target;
  vel_t        offset;
  logic [31:0] limit;
  vel_t        cmd_q;

  modport sat  (input cycle, input target, input offset, input limit, output cmd_q);
  modport ctrl (output cycle, output target, output offset, output limit, input cmd_q);
endinterface : csv_vel_if

`default_nettype wire

// [rtl/csv_vel_sat.sv]
`include "csv_regs.svh"
`default_nettype none

module csv_vel_sat
  import csv_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  csv_vel_if.sat    vif
);

  // Wide sum so the signed overflow is seen, not wrapped
  logic signed [32:0] sum_w;
  logic signed [32:0] lim_w;
  logic signed [32:0] sat_w;
  logic [31:0]        lim_u_w;

  assign sum_w   = {vif.target[31], vif.target} + {vif.offset[31], vif.offset};
  assign lim_u_w = (vif.limit > `VEL_CEIL) ? `VEL_CEIL : vif.limit;
  assign lim_w   = {1'b0, lim_u_w};
  assign sat_w   = (sum_w > lim_w)  ? lim_w :
                   (sum_w < -lim_w) ? -lim_w : sum_w;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      vif.cmd_q <= '0;
    else if (vif.cycle)
      vif.cmd_q <= vel_t'(sat_w[31:0]);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sat_upper_a: assert property (vif.cycle |=> $signed({vif.cmd_q[31], vif.cmd_q}) <= $past(lim_w))
    else $error("velocity command above limit");
  sat_lower_a: assert property (vif.cycle |=> $signed({vif.cmd_q[31], vif.cmd_q}) >= -$past(lim_w))
    else $error("velocity command below negative limit");
  sum_pass_a: assert property (vif.cycle && sum_w <= lim_w && sum_w >= -lim_w
                               |=> vif.cmd_q == $past(sum_w[31:0]))
    else $error("in-range sum not passed through");
  cmd_hold_a: assert property (!vif.cycle |=> $stable(vif.cmd_q))
    else $error("command moved between cycles");
  sat_hit_c: cover property (vif.cycle && sum_w > lim_w);

endmodule : csv_vel_sat

`default_nettype wire

// [rtl/csv_status_vel.sv]
// Summary of operation
// - Status bit 12 shows command following
// - Flag high only in operation enabled
// - Flag low during any deceleration
// - Flag low while halted
// - Flag low on overtravel in commanded direction
// - Torque limit clears flag when bit11 zero
// - Bit11 set excludes torque/cst speed limits
// - Command is target plus offset
// - Clamp to lesser of max speed, ceiling
// - Max speed latched at operation start
// - Mode-specific control word bits ignored
`include "csv_regs.svh"
`default_nettype none

module csv_status_vel
  import csv_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        cycle_strobe,
  input  wire logic        op_enabled,
  input  wire logic        decel_active,
  input  wire logic        halt_status,
  input  wire word_t       controlword,
  input  wire logic        positive_overtravel,
  input  wire logic        negative_overtravel,
  input  wire logic        torque_limit_active,
  input  wire logic        speed_limit_active,
  input  wire logic        cst_mode,
  input  wire word_t       pds_status_bits,
  input  wire vel_t        target_velocity,
  input  wire vel_t        velocity_offset,
  input  wire logic [31:0] max_motor_speed,
  input  wire logic        obj_wr,
  input  wire logic        obj_rd,
  input  wire word_t       obj_index,
  input  wire word_t       obj_wdata,
  output var  word_t       obj_rdata_q,
  output var  logic        obj_ack_q,
  output var  word_t       status_word_q,
  output var  logic        follows_q,
  output var  vel_t        velocity_cmd_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Overtravel pins are asynchronous
  logic [1:0]  pot_sync_q;
  logic [1:0]  not_sync_q;
  word_t       ext_setup_q;
  logic [31:0] max_lat_q;
  run_state_t  state_q;
  run_state_t  state_d;
  vel_t        vel_q;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pot_sync_q <= '0;
      not_sync_q <= '0;
    end
    else
    begin
      pot_sync_q <= {pot_sync_q[0], positive_overtravel};
      not_sync_q <= {not_sync_q[0], negative_overtravel};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Object access
  logic wr_ext_w;
  logic sel_ext_w;
  logic sel_sw_w;
  word_t rdata_w;

  assign sel_ext_w = (obj_index == `IDX_EXT_SETUP3);
  assign sel_sw_w  = (obj_index == `IDX_STATUS_WORD);
  // Status word is read-only; writes to it are dropped
  assign wr_ext_w  = obj_wr && sel_ext_w;
  assign rdata_w   = sel_ext_w ? ext_setup_q : sel_sw_w ? status_word_q : '0;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ext_setup_q <= `EXT_SETUP3_RST;
      obj_rdata_q <= '0;
      obj_ack_q   <= 1'b0;
    end
    else
    begin
      if (wr_ext_w)
        ext_setup_q <= obj_wdata;
      if (obj_rd)
        obj_rdata_q <= rdata_w;
      obj_ack_q <= obj_rd || obj_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed limit latch
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (op_enabled) state_d = ST_RUN;
      ST_RUN:  if (!op_enabled) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_q   <= ST_IDLE;
      max_lat_q <= `SPEED_RST;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_IDLE)
        max_lat_q <= max_motor_speed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Velocity command path
  csv_vel_if vif ();

  assign vif.cycle  = cycle_strobe;
  assign vif.target = target_velocity;
  assign vif.offset = velocity_offset;
  assign vif.limit  = max_lat_q;
  assign vel_q      = vif.cmd_q;

  csv_vel_sat u_sat (
    .clk  (clk),
    .nrst (nrst),
    .vif  (vif.sat)
  );

  assign velocity_cmd_q = vel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Follows-command flag
  logic  dir_pos_w;
  logic  dir_neg_w;
  logic  cw_halt_w;
  logic  ot_block_w;
  logic  lim_block_w;
  logic  hold_ok_w;
  logic  cond_w;
  logic  follows_d;
  word_t sw_d;

  assign dir_neg_w = vel_q[31];
  assign dir_pos_w = !vel_q[31] && (vel_q != '0);
  // Only the halt bit is read
  assign cw_halt_w = controlword[`CW_HALT_BIT];
  assign ot_block_w = (pot_sync_q[1] && dir_pos_w) || (not_sync_q[1] && dir_neg_w);
  // Limits count only when bit11 clear
  assign lim_block_w = !ext_setup_q[`EXT_TQLIM_BIT] &&
                       (torque_limit_active || (cst_mode && speed_limit_active));
  assign hold_ok_w = op_enabled && !decel_active && !halt_status;
  assign cond_w = hold_ok_w && !cw_halt_w && !ot_block_w && !lim_block_w;
  // Set only at the cycle strobe; enable, decel and halt clears need not wait
  assign follows_d = cycle_strobe ? cond_w : (follows_q && hold_ok_w);
  assign sw_d = (pds_status_bits & `SW_PASS_MASK) | (word_t'(follows_d) << `SW_FOLLOW_BIT);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      follows_q     <= 1'b0;
      status_word_q <= '0;
    end
    else
    begin
      follows_q     <= follows_d;
      status_word_q <= sw_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sw_bit_mirror_a: assert property (status_word_q[`SW_FOLLOW_BIT] == follows_q)
    else $error("status bit 12 differs from flag");
  only_enabled_a: assert property (!op_enabled |=> !follows_q)
    else $error("flag high outside operation enabled");
  decel_clear_a: assert property (decel_active |=> !follows_q)
    else $error("flag high during deceleration");
  halt_clear_a: assert property (halt_status |=> !follows_q)
    else $error("flag high while halted");
  overtravel_block_a: assert property (cycle_strobe && ot_block_w |=> !follows_q)
    else $error("flag high against overtravel");
  torque_limit_a: assert property (cycle_strobe && torque_limit_active
                                   && !ext_setup_q[`EXT_TQLIM_BIT] |=> !follows_q)
    else $error("flag high under torque limit");
  limit_excluded_a: assert property (cycle_strobe && ext_setup_q[`EXT_TQLIM_BIT] && hold_ok_w
                                     && !cw_halt_w && !ot_block_w |=> follows_q)
    else $error("excluded limit cleared flag");
  speed_frozen_a: assert property (state_q == ST_RUN && op_enabled |=> $stable(max_lat_q))
    else $error("speed limit changed during operation");
  cycle_only_set_a: assert property (!cycle_strobe && !follows_q |=> !follows_q)
    else $error("flag rose between cycles");
  ignore_oms_a: assert property (cycle_strobe && cond_w ##1 !cycle_strobe && hold_ok_w
                                 && $changed(controlword) |=> follows_q)
    else $error("control word bits disturbed flag");

  follow_rise_c: cover property (!follows_q ##1 follows_q);
  overtravel_c:  cover property (cycle_strobe && ot_block_w);
  run_cycle_c:   cover property (state_q == ST_IDLE ##1 state_q == ST_RUN);

endmodule : csv_status_vel

`default_nettype wire

// [testbench/csv_master_model.sv]
`default_nettype none

module csv_master_model
  import csv_pkg::*;
(
  input  wire logic clk,
  input  wire logic go,
  input  wire vel_t tgt,
  input  wire vel_t off,
  output var  logic cycle_strobe,
  output var  vel_t target_velocity,
  output var  vel_t velocity_offset
);
  timeunit 1ns;
  timeprecision 1ps;
  // One pair per period
  // Values flip outside the strobe so stale data cannot pass
  always_ff @(posedge clk)
  begin
    cycle_strobe    <= go;
    target_velocity <= go ? tgt : ~target_velocity;
    velocity_offset <= go ? off : ~velocity_offset;
  end
endmodule : csv_master_model

`default_nettype wire

// [testbench/csv_status_and_velocity_command_bench.sv]
`default_nettype none

module csv_status_and_velocity_command_bench
  import csv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, nrst = 1'b0, go = 1'b0, op = 1'b0, dec = 1'b0, hlt = 1'b0;
  logic        pos_ot = 1'b0, neg_ot = 1'b0, tq = 1'b0, spd = 1'b0, cst = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, cs, ack, fol;
  word_t       cw = 16'h0000, power_drive_state_machine = 16'hffff, idx = 16'h0000, wd = 16'h0000, rdat, sw;
  vel_t        tgt = 32'sh0, off = 32'sh0, tv, vo, cmd;
  logic [31:0] mx = 32'h0000_03e8;
  int          error_cnt = 0, checks_done = 0;

  ////////////////////////////////////////////////////////////
  csv_master_model master (.clk(clk), .go(go), .tgt(tgt), .off(off), .cycle_strobe(cs),
    .target_velocity(tv), .velocity_offset(vo));

  csv_status_vel DUT (.clk(clk), .nrst(nrst), .cycle_strobe(cs), .op_enabled(op),
    .decel_active(dec), .halt_status(hlt), .controlword(cw), .positive_overtravel(pos_ot),
    .negative_overtravel(neg_ot), .torque_limit_active(tq), .speed_limit_active(spd),
    .cst_mode(cst), .pds_status_bits(power_drive_state_machine), .target_velocity(tv), .velocity_offset(vo),
    .max_motor_speed(mx), .obj_wr(wr), .obj_rd(rd), .obj_index(idx), .obj_wdata(wd),
    .obj_rdata_q(rdat), .obj_ack_q(ack), .status_word_q(sw), .follows_q(fol),
    .velocity_cmd_q(cmd));

  initial forever #5 clk = ~clk;

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic obj(input logic w, input word_t i, input word_t d, input word_t e);
    @(posedge clk);
    wr  <= w;
    rd  <= !w;
    idx <= i;
    wd  <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 chk(ack, 1'b1);
    if (!w)
      chk(rdat, e);
  endtask : obj

  // Status expected with all passed-through bits set
  task automatic cyc(input vel_t t, input vel_t o, input vel_t ec, input logic ef);
    @(posedge clk);
    go  <= 1'b1;
    tgt <= t;
    off <= o;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(cmd, ec);
    chk(fol, ef);
    chk(sw, {3'b000, ef, 12'hbff});
  endtask : cyc

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    obj(1'b0, 16'h3724, 16'h0000, 16'h0000);
    obj(1'b1, 16'h6041, 16'h5555, 16'h0000);
    obj(1'b0, 16'h6041, 16'h0000, 16'h0bff);
    obj(1'b0, 16'h1234, 16'h0000, 16'h0000);
    obj(1'b1, 16'h3724, 16'h0800, 16'h0000);
    obj(1'b0, 16'h3724, 16'h0000, 16'h0800);
    obj(1'b1, 16'h3724, 16'h0000, 16'h0000);
    $display("test registers done");
    cyc(100, 20, 120, 1'b0);
    // Enable wait shortened, design ignores it
    @(posedge clk) op <= 1'b1;
    cyc(100, 20, 120, 1'b1);
    cyc(2000, 0, 1000, 1'b1);
    cyc(-900, -200, -1000, 1'b1);
    @(posedge clk) mx <= 32'h0000_0005;
    cyc(700, 0, 700, 1'b1);
    @(posedge clk) op <= 1'b0;
    cyc(100, 20, 5, 1'b0);
    @(posedge clk) mx <= 32'hffff_ffff;
    @(posedge clk) op <= 1'b1;
    cyc(32'sh7fffffff, 1, 32'sh7fffffff, 1'b1);
    cyc(-32'sh7fffffff, -5, -32'sh7fffffff, 1'b1);
    $display("test velocity done");
    @(posedge clk) dec <= 1'b1;
    cyc(10, 0, 10, 1'b0);
    @(posedge clk) {dec, hlt} <= 2'b01;
    cyc(10, 0, 10, 1'b0);
    @(posedge clk) {hlt, cw} <= {1'b0, 16'hfeff};
    // Control word moves right after the strobe edge
    fork
      cyc(10, 0, 10, 1'b1);
      begin
        repeat (3) @(posedge clk);
        cw <= 16'h0000;
      end
    join
    @(posedge clk) {cw, pos_ot} <= {16'h0000, 1'b1};
    cyc(50, 0, 50, 1'b0);
    cyc(-50, 0, -50, 1'b0);
    cyc(-50, 0, -50, 1'b1);
    @(posedge clk) neg_ot <= 1'b1;
    cyc(-50, 0, -50, 1'b0);
    @(posedge clk) {pos_ot, neg_ot, tq} <= 3'b001;
    cyc(10, 0, 10, 1'b0);
    obj(1'b1, 16'h3724, 16'h0800, 16'h0000);
    cyc(10, 0, 10, 1'b1);
    obj(1'b1, 16'h3724, 16'h0000, 16'h0000);
    @(posedge clk) {tq, spd} <= 2'b01;
    cyc(10, 0, 10, 1'b1);
    @(posedge clk) cst <= 1'b1;
    cyc(10, 0, 10, 1'b0);
    $display("test conditions done");
    // Mid-run reset must clear setup and outputs
    obj(1'b1, 16'h3724, 16'h0800, 16'h0000);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(cmd, 32'h0000_0000);
    chk(fol, 1'b0);
    obj(1'b0, 16'h3724, 16'h0000, 16'h0000);
    $display("test reset done");
    report_and_stop();
  end
endmodule : csv_status_and_velocity_command_bench

`default_nettype wire
